// [inc/rxdp_pkg.sv]
// Package: register map, field positions and carriers for the receive path control block
package rxdp_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] CTRL_ADDR = 12'h0340;
   localparam logic [11:0] STAT_ADDR = 12'h0344;
   localparam int          ADDR_W    = 12;

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   localparam int CTRL_CCLR_B   = 9;
   localparam int CTRL_CCLR_A   = 8;
   localparam int CTRL_EMPTY_B  = 7;
   localparam int CTRL_EMPTY_A  = 6;
   localparam int CTRL_CRCDROP  = 5;
   localparam int CTRL_FULLSID  = 2;
   localparam int CTRL_TARDY    = 1;
   localparam int CTRL_BUSYALL  = 0;
   localparam logic CRCDROP_RST = 1'b1;

   // ----------------------------------------------------------------
   // Status fields
   // ----------------------------------------------------------------
   localparam int STAT_EMI_B_HI = 15;
   localparam int STAT_EMI_B_LO = 14;
   localparam int STAT_EMI_A_HI = 13;
   localparam int STAT_EMI_A_LO = 12;
   localparam int STAT_POB_A    = 11;
   localparam int STAT_POB_B    = 10;
   localparam int STAT_CONFLICT = 0;

   // ----------------------------------------------------------------
   // Acknowledge codes and sizes
   // ----------------------------------------------------------------
   localparam logic [3:0] ACK_TARDY_CODE  = 4'hB;
   localparam logic [3:0] ACK_BUSYX_CODE  = 4'h4;
   localparam logic [3:0] ACK_NORMAL_CODE = 4'h0;
   localparam int         NUM_BUF         = 8;
   localparam int         DBC_W           = 8;
   localparam logic [DBC_W-1:0] DBC_ZERO  = 8'h00;
   localparam logic [DBC_W-1:0] DBC_ONE   = 8'h01;
   localparam logic [31:0]      WORD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      VID_NONE = 2'h0,
      VID_A    = 2'h1,
      VID_B    = 2'h2
   } vid_type_t;

   // Per-packet receive event from the link receive path
   typedef struct packed {
      logic       stream_b;     // 0 = stream A, 1 = stream B
      logic       is_empty;
      logic       crc_error;
      logic       is_selfid;
      logic       is_async;
      logic [1:0] emi;
      logic       parity_phase;
      logic [DBC_W-1:0] dbc;
   } rx_pkt_t;

   // Decision handed downstream
   typedef struct packed {
      logic       accept;
      logic       flush;
      logic       store_full_selfid;
      logic       dbc_error;
      logic [3:0] ack_code;
      logic       stream_b;
   } rx_verdict_t;

endpackage

// [hw/rx_skid2.sv]
// Two-entry valid/ready buffer for receive verdicts
`timescale 1ns/1ps
module rx_skid2 (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  clk_en,
   // Fill side
   input  wire logic                  in_valid,
   output logic                       in_ready,
   input  wire rxdp_pkg::rx_verdict_t in_data,
   // Drain side
   output logic                       out_valid,
   input  wire logic                  out_ready,
   output rxdp_pkg::rx_verdict_t      out_data
);
   import rxdp_pkg::*;

   rx_verdict_t mem_q [2];
   rx_verdict_t mem_d [2];
   logic        wptr_q, wptr_d, rptr_q, rptr_d;
   logic [1:0]  cnt_q, cnt_d;
   logic        push, pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign out_data  = mem_q[rptr_q];

   always_comb begin
      mem_d  = mem_q;
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      cnt_d  = cnt_q;
      if (push) begin
         mem_d[wptr_q] = in_data;
         wptr_d        = ~wptr_q;
      end
      if (pop) begin
         rptr_d = ~rptr_q;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 2'd1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wptr_q   <= 1'b0;
         rptr_q   <= 1'b0;
         cnt_q    <= 2'd0;
      end else if (clk_en) begin
         mem_q  <= mem_d;
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q  <= cnt_d;
      end
   end
endmodule

// [hw/rx_datapath_ctrl_status.sv]
// Receive data path lower control bits, status register and packet verdicts
// Overview of operation
// - Writing one to bit 9 or 8 clears the continuity counter of stream B or A; the bit reads 0.
// - Bits 7 and 6 let empty packets of stream B and A be accepted, and both reset to zero.
// - Bit 5, reset to one, makes packets with a payload CRC error be aborted and flushed.
// - Reserved control bits 4:3 and status bits 31:16 and 9:1 ignore writes and read zero.
// - Bit 2 set stores both self-ID quadlets, otherwise only the reduced form is stored.
// - Bit 1 set answers every asynchronous packet with tardy code B unless busy-all is set.
// - Bit 0 set answers every asynchronous packet with busy code 4, overriding tardy.
// - Status bits 15:14 and 13:12 show the encryption indicator of stream B and A, reset 0.
// - Status bits 11 and 10 hold the parity phase bit of stream A and B from every packet that is neither asynchronous nor self-ID.
// - Status bit 0 is set while two or more buffers are configured as the same video type, A or B.
// - Status bit 0 clears itself once the video type conflict is gone.
`timescale 1ns/1ps
module rx_datapath_ctrl_status (
   // Clock, reset, enable
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  clk_en,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Buffer video type configuration
   input  wire rxdp_pkg::vid_type_t   buf_vid_type [rxdp_pkg::NUM_BUF],
   // Incoming packet events
   input  wire logic                  pkt_valid,
   output logic                       pkt_ready,
   input  wire rxdp_pkg::rx_pkt_t     pkt,
   // Packet verdicts
   output logic                       verdict_valid,
   input  wire logic                  verdict_ready,
   output rxdp_pkg::rx_verdict_t      verdict,
   // Continuity counters
   output logic [7:0]                 dbc_count_a,
   output logic [7:0]                 dbc_count_b
);
   import rxdp_pkg::*;

   // ----------------------------------------------------------------
   // Control and status state
   // ----------------------------------------------------------------
   logic       empty_b_q, empty_b_d, empty_a_q, empty_a_d;
   logic       crcdrop_q, crcdrop_d, fullsid_q, fullsid_d;
   logic       tardy_q, tardy_d, busyall_q, busyall_d;
   logic [1:0] emi_b_q, emi_b_d, emi_a_q, emi_a_d;
   logic       pob_a_q, pob_a_d, pob_b_q, pob_b_d;
   logic       conflict_q, conflict_d;
   logic [DBC_W-1:0] dbc_a_q, dbc_a_d, dbc_b_q, dbc_b_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d, pslverr_q, pslverr_d;

   logic        setup, access, wr_ctrl, clr_a, clr_b, mapped;
   logic [31:0] ctrl_word, stat_word;
   logic        pkt_take, sk_in_ready;
   rx_verdict_t vd;
   logic [NUM_BUF-1:0] has_a, has_b;
   logic        dup_a, dup_b;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign setup   = psel && !penable;
   // Writes land at the access edge, where the master samples pready high
   assign access  = psel && penable && pready_q;
   assign mapped  = (paddr == CTRL_ADDR) || (paddr == STAT_ADDR);
   assign wr_ctrl = access && pwrite && (paddr == CTRL_ADDR);
   assign clr_b   = wr_ctrl && pstrb[1] && pwdata[CTRL_CCLR_B];
   assign clr_a   = wr_ctrl && pstrb[1] && pwdata[CTRL_CCLR_A];

   always_comb begin
      ctrl_word               = WORD_ZERO;
      ctrl_word[CTRL_EMPTY_B] = empty_b_q;
      ctrl_word[CTRL_EMPTY_A] = empty_a_q;
      ctrl_word[CTRL_CRCDROP] = crcdrop_q;
      ctrl_word[CTRL_FULLSID] = fullsid_q;
      ctrl_word[CTRL_TARDY]   = tardy_q;
      ctrl_word[CTRL_BUSYALL] = busyall_q;
   end

   always_comb begin
      stat_word                              = WORD_ZERO;
      stat_word[STAT_EMI_B_HI:STAT_EMI_B_LO] = emi_b_q;
      stat_word[STAT_EMI_A_HI:STAT_EMI_A_LO] = emi_a_q;
      stat_word[STAT_POB_A]                  = pob_a_q;
      stat_word[STAT_POB_B]                  = pob_b_q;
      stat_word[STAT_CONFLICT]               = conflict_q;
   end

   // Answer one cycle after setup, so pready is high during the access phase
   always_comb begin
      pready_d  = setup;
      pslverr_d = setup && !mapped;
      prdata_d  = prdata_q;
      if (setup) begin
         prdata_d = WORD_ZERO;
         if (!pwrite && paddr == CTRL_ADDR) begin
            prdata_d = ctrl_word;
         end else if (!pwrite && paddr == STAT_ADDR) begin
            prdata_d = stat_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_comb begin
      empty_b_d = empty_b_q;
      empty_a_d = empty_a_q;
      crcdrop_d = crcdrop_q;
      fullsid_d = fullsid_q;
      tardy_d   = tardy_q;
      busyall_d = busyall_q;
      if (wr_ctrl && pstrb[0]) begin
         empty_b_d = pwdata[CTRL_EMPTY_B];
         empty_a_d = pwdata[CTRL_EMPTY_A];
         crcdrop_d = pwdata[CTRL_CRCDROP];
         fullsid_d = pwdata[CTRL_FULLSID];
         tardy_d   = pwdata[CTRL_TARDY];
         busyall_d = pwdata[CTRL_BUSYALL];
      end
   end

   // ----------------------------------------------------------------
   // Video type conflict across buffers
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BUF; gi++) begin : g_buf
         assign has_a[gi] = (buf_vid_type[gi] == VID_A);
         assign has_b[gi] = (buf_vid_type[gi] == VID_B);
      end
   endgenerate

   // More than one bit set means a duplicate assignment
   assign dup_a      = (has_a & (has_a - 8'h01)) != 8'h00;
   assign dup_b      = (has_b & (has_b - 8'h01)) != 8'h00;
   assign conflict_d = dup_a || dup_b;

   // ----------------------------------------------------------------
   // Packet verdict and stream status
   // ----------------------------------------------------------------
   assign pkt_ready = sk_in_ready;
   assign pkt_take  = pkt_valid && sk_in_ready;

   always_comb begin
      vd                   = '0;
      vd.stream_b          = pkt.stream_b;
      vd.accept            = !pkt.is_empty || (pkt.stream_b ? empty_b_q : empty_a_q);
      vd.flush             = pkt.crc_error && crcdrop_q;
      vd.store_full_selfid = pkt.is_selfid && fullsid_q;
      vd.dbc_error         = pkt.dbc != (pkt.stream_b ? dbc_b_q : dbc_a_q);
      vd.ack_code          = ACK_NORMAL_CODE;
      if (pkt.is_async) begin
         if (busyall_q) begin
            vd.ack_code = ACK_BUSYX_CODE;
         end else if (tardy_q) begin
            vd.ack_code = ACK_TARDY_CODE;
         end
      end
      if (vd.flush || pkt.is_async) begin
         vd.accept = vd.accept && !vd.flush;
      end
   end

   // Stream status fields move only with received packets, the continuity counters also with a software clear
   always_comb begin
      emi_b_d = emi_b_q;
      emi_a_d = emi_a_q;
      pob_b_d = pob_b_q;
      pob_a_d = pob_a_q;
      dbc_a_d = dbc_a_q;
      dbc_b_d = dbc_b_q;
      if (pkt_take && !pkt.is_async && !pkt.is_selfid) begin
         if (pkt.stream_b) begin
            emi_b_d = pkt.emi;
            pob_b_d = pkt.parity_phase;
            dbc_b_d = pkt.dbc + DBC_ONE;
         end else begin
            emi_a_d = pkt.emi;
            pob_a_d = pkt.parity_phase;
            dbc_a_d = pkt.dbc + DBC_ONE;
         end
      end
      // Software clear wins over a concurrent packet update
      if (clr_a) begin
         dbc_a_d = DBC_ZERO;
      end
      if (clr_b) begin
         dbc_b_d = DBC_ZERO;
      end
   end

   rx_skid2 u_skid (
      .clk       (clk),
      .nrst      (nrst),
      .clk_en    (clk_en),
      .in_valid  (pkt_valid),
      .in_ready  (sk_in_ready),
      .in_data   (vd),
      .out_valid (verdict_valid),
      .out_ready (verdict_ready),
      .out_data  (verdict)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         empty_b_q  <= 1'b0;
         empty_a_q  <= 1'b0;
         crcdrop_q  <= CRCDROP_RST;
         fullsid_q  <= 1'b0;
         tardy_q    <= 1'b0;
         busyall_q  <= 1'b0;
         emi_b_q    <= 2'b00;
         emi_a_q    <= 2'b00;
         pob_a_q    <= 1'b0;
         pob_b_q    <= 1'b0;
         conflict_q <= 1'b0;
         dbc_a_q    <= DBC_ZERO;
         dbc_b_q    <= DBC_ZERO;
         prdata_q   <= WORD_ZERO;
         pready_q   <= 1'b0;
         pslverr_q  <= 1'b0;
      end else if (clk_en) begin
         empty_b_q  <= empty_b_d;
         empty_a_q  <= empty_a_d;
         crcdrop_q  <= crcdrop_d;
         fullsid_q  <= fullsid_d;
         tardy_q    <= tardy_d;
         busyall_q  <= busyall_d;
         emi_b_q    <= emi_b_d;
         emi_a_q    <= emi_a_d;
         pob_a_q    <= pob_a_d;
         pob_b_q    <= pob_b_d;
         conflict_q <= conflict_d;
         dbc_a_q    <= dbc_a_d;
         dbc_b_q    <= dbc_b_d;
         prdata_q   <= prdata_d;
         pready_q   <= pready_d;
         pslverr_q  <= pslverr_d;
      end
   end

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign dbc_count_a = dbc_a_q;
   assign dbc_count_b = dbc_b_q;
endmodule

// [dv/rx_pkt_partner.sv]
// Packet source and stalling verdict sink for the receive path
`timescale 1ns/1ps
module rx_pkt_partner (
   // Clock
   input  wire logic                  clk,
   // Packets out
   output logic                       pkt_valid,
   input  wire logic                  pkt_ready,
   output rxdp_pkg::rx_pkt_t          pkt,
   // Verdicts in
   input  wire logic                  verdict_valid,
   output logic                       verdict_ready,
   input  wire rxdp_pkg::rx_verdict_t verdict
);
   import rxdp_pkg::*;
   rx_verdict_t got [$];
   logic        stall = 1'b0;
   assign verdict_ready = !stall;
   initial begin
      pkt_valid = 1'b0;
      pkt = '0;
   end
   always @(posedge clk) begin
      if (verdict_valid && verdict_ready)
         got.push_back(verdict);
   end
   // Holds the packet until taken, then scrambles the idle lines
   task automatic send(input rx_pkt_t p);
      pkt_valid <= 1'b1;
      pkt <= p;
      do @(posedge clk); while (pkt_ready !== 1'b1);
      pkt_valid <= 1'b0;
      pkt <= ~p;
   endtask
endmodule

// [dv/rx_datapath_ctrl_status_asserts.sv]
// Port checker for the receive path control and status block
`timescale 1ns/1ps
module rx_datapath_ctrl_status_asserts (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  nrst,
   // APB
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   // Receive side
   input wire rxdp_pkg::vid_type_t   buf_vid_type [rxdp_pkg::NUM_BUF],
   input wire logic                  pkt_valid,
   input wire logic                  pkt_ready,
   input wire rxdp_pkg::rx_pkt_t     pkt,
   input wire logic                  verdict_valid,
   input wire rxdp_pkg::rx_verdict_t verdict,
   input wire logic [7:0]            dbc_count_a
);
   import rxdp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ------
   // Control shadow and expected fields
   // ------
   logic [7:0] sh_q;
   logic       setup, acc, take, conf, e_flush, e_sid, e_acc, rd_st;
   int         na, nb;
   assign setup = psel && !penable;
   // Write completes at the edge where pready is sampled high in the access phase
   assign acc = psel && penable && pready;
   assign rd_st = setup && !pwrite && paddr == STAT_ADDR;
   // A packet into an empty buffer shows its verdict on the next cycle
   assign take = pkt_valid && pkt_ready && !verdict_valid;
   assign e_flush = pkt.crc_error && sh_q[CTRL_CRCDROP];
   assign e_sid = pkt.is_selfid && sh_q[CTRL_FULLSID];
   assign e_acc = (!pkt.is_empty || sh_q[CTRL_EMPTY_A + pkt.stream_b]) && !e_flush;
   assign conf = (na > 1) || (nb > 1);
   always_comb begin
      na = 0;
      nb = 0;
      for (int i = 0; i < NUM_BUF; i++) begin
         na += int'(buf_vid_type[i] == VID_A);
         nb += int'(buf_vid_type[i] == VID_B);
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst)
         sh_q <= 8'h20;
      else if (acc && pwrite && paddr == CTRL_ADDR)
         sh_q <= pwdata[7:0];
   end
   AST_BUSY_ACK: assert property (take && pkt.is_async && sh_q[0] |=> verdict.ack_code == 4'h4)
      else $error("busy ack code wrong");
   AST_TARDY_ACK: assert property (take && pkt.is_async && sh_q[1:0] == 2'b10 |=>
      verdict_valid && verdict.ack_code == ACK_TARDY_CODE) else $error("tardy ack code wrong");
   AST_CRC_DROP: assert property (take |=> verdict.flush == $past(e_flush))
      else $error("flush on payload error wrong");
   AST_FULL_SID: assert property (take |=> verdict.store_full_selfid == $past(e_sid))
      else $error("self-ID store form wrong");
   AST_EMPTY_ACC: assert property (take |=> verdict.accept == $past(e_acc))
      else $error("empty packet acceptance wrong");
   AST_CLR_A: assert property (acc && pwrite && paddr == CTRL_ADDR && pwdata[8] |=>
      dbc_count_a == DBC_ZERO) else $error("counter A not cleared");
   AST_RSVD: assert property (rd_st |=> prdata[31:16] == 16'h0000 && prdata[9:1] == 9'h000)
      else $error("reserved status bits not zero");
   AST_CONF_SET: assert property (rd_st && conf && $past(conf) |=> prdata[0])
      else $error("conflict bit not set");
   AST_CONF_CLR: assert property (rd_st && !conf && !$past(conf) |=> !prdata[0])
      else $error("conflict bit not cleared");
   cover property (take && pkt.is_async && sh_q[0]);
   cover property (rd_st && conf);
   cover property (pkt_valid && !pkt_ready);
endmodule
bind rx_datapath_ctrl_status rx_datapath_ctrl_status_asserts chk (.clk(clk), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .buf_vid_type(buf_vid_type), .pkt_valid(pkt_valid),
   .pkt(pkt),
   .pkt_ready(pkt_ready), .verdict_valid(verdict_valid), .verdict(verdict),
   .dbc_count_a(dbc_count_a));

// [dv/rx_datapath_ctrl_status_tb_top.sv]
// Testbench for the receive path control and status block
`timescale 1ns/1ps
module rx_datapath_ctrl_status_tb_top;
   import rxdp_pkg::*;
   // ------
   // Hookup
   // ------
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rdat;
   logic        pready, pslverr, rerr, pkt_valid, pkt_ready, verdict_valid, verdict_ready;
   vid_type_t   bvt [NUM_BUF] = '{default: VID_NONE};
   rx_pkt_t     pkt;
   rx_verdict_t verdict;
   logic [7:0]  dbc_count_a, dbc_count_b;
   logic [7:0]  ctl = 8'h20;
   logic [7:0]  cnt [2] = '{8'h00, 8'h00};
   int          error_cnt = 0;
   int          samples_checked = 0;
   rx_datapath_ctrl_status uut (.clk(clk), .nrst(nrst), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .buf_vid_type(bvt),
      .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt(pkt), .verdict_valid(verdict_valid),
      .verdict_ready(verdict_ready), .verdict(verdict), .dbc_count_a(dbc_count_a),
      .dbc_count_b(dbc_count_b));
   rx_pkt_partner pt (.clk(clk), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt(pkt),
      .verdict_valid(verdict_valid), .verdict_ready(verdict_ready), .verdict(verdict));
   initial forever #10 clk = ~clk;
   // ------
   // Bus, compare and packet tasks
   // ------
   task automatic finish_test;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_vd(input rx_verdict_t g, input rx_verdict_t e);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t: verdict %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) chk(32'h0000_0000, 32'h0000_0001);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == CTRL_ADDR) begin
         ctl = d[7:0] & 8'hE7;
         if (d[8]) cnt[0] = DBC_ZERO;
         if (d[9]) cnt[1] = DBC_ZERO;
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask
   function automatic rx_verdict_t ev(input rx_pkt_t p);
      rx_verdict_t v;
      v.flush = p.crc_error && ctl[CTRL_CRCDROP];
      v.accept = (!p.is_empty || ctl[CTRL_EMPTY_A + p.stream_b]) && !v.flush;
      v.store_full_selfid = p.is_selfid && ctl[CTRL_FULLSID];
      v.dbc_error = p.dbc != cnt[p.stream_b];
      v.ack_code = !p.is_async ? ACK_NORMAL_CODE : ctl[0] ? ACK_BUSYX_CODE :
                   ctl[1] ? ACK_TARDY_CODE : ACK_NORMAL_CODE;
      v.stream_b = p.stream_b;
      if (!p.is_async && !p.is_selfid) cnt[p.stream_b] = p.dbc + DBC_ONE;
      return v;
   endfunction
   task automatic xfer(input rx_pkt_t p);
      rx_verdict_t e;
      int n;
      e = ev(p);
      n = 0;
      pt.send(p);
      while (pt.got.size() == 0 && n++ < 20) @(posedge clk);
      chk(pt.got.size(), 1);
      if (pt.got.size() != 0) chk_vd(pt.got.pop_front(), e);
   endtask
   // ------
   // Scenarios
   // ------
   task automatic t_regs;
      rd(CTRL_ADDR, 32'h0000_0020);
      rd(STAT_ADDR, WORD_ZERO);
      wr(CTRL_ADDR, 32'hFFFF_FFFF);
      rd(CTRL_ADDR, 32'h0000_00E7);
      wr(STAT_ADDR, 32'hFFFF_FFFF);
      rd(STAT_ADDR, WORD_ZERO);
      rd(12'h348, WORD_ZERO);
      chk(rerr, 1'b1);
   endtask
   task automatic t_ack;
      for (int i = 0; i < 4; i++) begin
         wr(CTRL_ADDR, i);
         xfer('{is_async: 1'b1, default: '0});
      end
      xfer('{stream_b: 1'b1, default: '0});
   endtask
   task automatic t_filt;
      logic [31:0] cv [2] = '{32'h0000_0000, 32'h0000_00E4};
      foreach (cv[i]) begin
         wr(CTRL_ADDR, cv[i]);
         xfer('{crc_error: 1'b1, is_async: 1'b1, default: '0});
         xfer('{is_empty: 1'b1, default: '0});
         xfer('{stream_b: 1'b1, is_empty: 1'b1, default: '0});
         xfer('{is_selfid: 1'b1, default: '0});
      end
   endtask
   task automatic t_stat;
      wr(CTRL_ADDR, WORD_ZERO);
      xfer('{emi: 2'b10, parity_phase: 1'b1, dbc: 8'h05, default: '0});
      xfer('{stream_b: 1'b1, emi: 2'b01, dbc: 8'h09, default: '0});
      rd(STAT_ADDR, 32'h0000_6800);
      chk(dbc_count_a, 8'h06);
      chk(dbc_count_b, 8'h0A);
      wr(CTRL_ADDR, 32'h0000_0100);
      chk(dbc_count_a, DBC_ZERO);
      chk(dbc_count_b, 8'h0A);
      xfer('{default: '0});
      rd(STAT_ADDR, 32'h0000_4000);
   endtask
   task automatic t_conf;
      bvt[0] <= VID_A;
      bvt[1] <= VID_A;
      repeat (2) @(posedge clk);
      rd(STAT_ADDR, 32'h0000_4001);
      bvt[1] <= VID_B;
      repeat (2) @(posedge clk);
      rd(STAT_ADDR, 32'h0000_4000);
      bvt[2] <= VID_B;
      repeat (2) @(posedge clk);
      rd(STAT_ADDR, 32'h0000_4001);
   endtask
   task automatic t_buf;
      rx_pkt_t     p1, p2;
      rx_verdict_t e1, e2;
      p1 = '{is_async: 1'b1, dbc: 8'h11, default: '0};
      p2 = '{is_async: 1'b1, dbc: 8'h22, default: '0};
      e1 = ev(p1);
      e2 = ev(p2);
      pt.stall <= 1'b1;
      pt.send(p1);
      @(posedge clk);
      pt.send(p2);
      @(posedge clk);
      chk(pkt_ready, 1'b0);
      chk(pt.got.size(), 0);
      pt.stall <= 1'b0;
      repeat (4) @(posedge clk);
      chk(pt.got.size(), 2);
      if (pt.got.size() == 2) begin
         chk_vd(pt.got.pop_front(), e1);
         chk_vd(pt.got.pop_front(), e2);
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_ack();
      t_filt();
      t_stat();
      t_conf();
      t_buf();
      finish_test();
   end
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
endmodule
